// [pkg/rvc_pkg.sv]
// Package for the regulator voltage code register slice: offsets, resets, carriers
package rvc_pkg;

   // ------------------------------------------------------------
   // Register offsets on the shared register port
   // ------------------------------------------------------------
   localparam logic [7:0] RVC_OFF_SD4  = 8'h94;
   localparam logic [7:0] RVC_OFF_SD5  = 8'h96;
   localparam logic [7:0] RVC_OFF_SD6  = 8'h98;
   localparam logic [7:0] RVC_OFF_LDA2 = 8'h9a;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] RVC_RST_SD4     = 8'h2f;
   localparam logic [7:0] RVC_RST_SD5     = 8'h4b;
   localparam logic [7:0] RVC_RST_SD6_A   = 8'h3d;
   localparam logic [7:0] RVC_RST_SD6_B   = 8'h47;
   localparam logic [7:0] RVC_RST_SD6_C   = 8'h56;
   localparam logic [7:0] RVC_RST_LDA2_ON = 8'haa;
   localparam logic [7:0] RVC_RST_LDA2_LO = 8'h00;
   localparam logic       RVC_RST_SLEEP_N = 1'h1;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int RVC_SD_MSB      = 6;
   localparam int RVC_LDA2_NRM_LSB = 0;
   localparam int RVC_LDA2_NRM_MSB = 3;
   localparam int RVC_LDA2_SLP_LSB = 4;
   localparam int RVC_LDA2_SLP_MSB = 7;
   localparam int RVC_SYNC_STAGES  = 2;

   // One-time-programmed variant selecting the OTP-dependent resets
   typedef enum logic [1:0] {
      RVC_VAR_A = 2'h0,   // sd6 0111101, a2 1010/1010
      RVC_VAR_B = 2'h1,   // sd6 1000111, a2 1010/1010
      RVC_VAR_C = 2'h3,   // sd6 1010110, a2 1010/1010
      RVC_VAR_D = 2'h2    // sd6 0111101, a2 0000/0000
   } rvc_variant_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rvc_req_t;

   typedef struct packed {
      logic [6:0] sd4;
      logic [6:0] sd5;
      logic [6:0] sd6;
      logic [3:0] lda2;
   } rvc_target_t;

   function automatic logic [7:0] rvc_sd6_reset(input rvc_variant_t v);
      case (v)
         RVC_VAR_B: rvc_sd6_reset = RVC_RST_SD6_B;
         RVC_VAR_C: rvc_sd6_reset = RVC_RST_SD6_C;
         default:   rvc_sd6_reset = RVC_RST_SD6_A;
      endcase
   endfunction

   function automatic logic [7:0] rvc_lda2_reset(input rvc_variant_t v);
      rvc_lda2_reset = (v == RVC_VAR_D) ? RVC_RST_LDA2_LO : RVC_RST_LDA2_ON;
   endfunction

endpackage

// [logic/rvc_sync2.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
`default_nettype none
module rvc_sync2 #(
   parameter int   WIDTH     = 1,
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic             clk_sys_in,   // System clock
   input  wire logic             rst_in,       // Synchronous reset, active high
   input  wire logic [WIDTH-1:0] async_in,     // Asynchronous level
   output logic      [WIDTH-1:0] sync_out      // Synchronised level
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         meta_r <= {WIDTH{RESET_VAL}};
         sync_r <= {WIDTH{RESET_VAL}};
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;

endmodule
`default_nettype wire

// [logic/rvc_regs.sv]
// Voltage code registers for step-down regulators 4, 5, 6 and low-dropout regulator A2
// Function
// - Step-down regulator 4 has a 7-bit read/write code in bits 6..0 that resets to 0101111.
// - Code 0x00 on a step-down code is a valid zero-volt setting and keeps power-good held high.
// - Step-down regulator 5 has a 7-bit read/write code in bits 6..0 that resets to 1001011.
// - Step-down regulator 6 has a 7-bit read/write code whose reset follows the OTP variant.
// - Regulator A2 has a 4-bit normal code in bits 3..0 resetting to 1010 or 0000 by variant.
// - Regulator A2 has a 4-bit sleep code in bits 7..4 applied while the sleep input is low.
`timescale 1ns/10ps
`default_nettype none
module rvc_regs (
   input  wire logic                  clk_sys_in,               // 40 MHz system clock
   input  wire logic                  rst_in,                   // Synchronous reset, active high
   input  wire rvc_pkg::rvc_req_t     reg_req_in,               // Register access request
   output logic                       reg_hit_out,              // Address maps to this slice
   output logic [7:0]                 reg_rdata_out,            // Read data, registered
   output logic                       reg_rvalid_out,           // Read data valid pulse
   input  wire rvc_pkg::rvc_variant_t otp_variant_in,           // OTP variant, same clock
   input  wire logic                  sleep_state_request_n_in, // Sleep pin, active low
   output rvc_pkg::rvc_target_t       target_out,               // Applied regulator codes
   output logic [2:0]                 pgood_hold_out            // Hold power-good, sd4/5/6
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0]           sd4_r;
   logic [7:0]           sd4_nxt;
   logic [7:0]           sd5_r;
   logic [7:0]           sd5_nxt;
   logic [7:0]           sd6_r;
   logic [7:0]           sd6_nxt;
   logic [7:0]           lda2_r;
   logic [7:0]           lda2_nxt;
   logic [7:0]           rdata_r;
   logic [7:0]           rdata_nxt;
   logic                 rvalid_r;
   logic                 rvalid_nxt;
   logic                 hit;
   rvc_pkg::rvc_target_t target_r;
   rvc_pkg::rvc_target_t target_nxt;
   logic [2:0]           hold_r;
   logic [2:0]           hold_nxt;
   logic                 sleep_n_sync;
   logic [6:0]           wdata_lo7;

   assign wdata_lo7 = reg_req_in.wdata[6:0];

   // ------------------------------------------------------------
   // Sleep pin crossing
   // ------------------------------------------------------------
   rvc_sync2 #(
      .WIDTH     (1),
      .RESET_VAL (rvc_pkg::RVC_RST_SLEEP_N)
   ) u_sleep_sync (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .async_in   (sleep_state_request_n_in),
      .sync_out   (sleep_n_sync)
   );

   // ------------------------------------------------------------
   // Register decode and write
   // ------------------------------------------------------------
   always_comb begin
      sd4_nxt  = sd4_r;
      sd5_nxt  = sd5_r;
      sd6_nxt  = sd6_r;
      lda2_nxt = lda2_r;
      hit      = 1'b1;
      if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD4) begin
         if (reg_req_in.wr) sd4_nxt = reg_req_in.wdata;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD5) begin
         if (reg_req_in.wr) sd5_nxt = reg_req_in.wdata;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD6) begin
         if (reg_req_in.wr) sd6_nxt = reg_req_in.wdata;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_LDA2) begin
         if (reg_req_in.wr) lda2_nxt = reg_req_in.wdata;
      end else begin
         hit = 1'b0;
      end
   end

   // Reads return the value before a same-cycle write; unmapped reads give zero
   always_comb begin
      rvalid_nxt = reg_req_in.rd;
      rdata_nxt  = 8'h00;
      if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD4) begin
         rdata_nxt = sd4_r;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD5) begin
         rdata_nxt = sd5_r;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_SD6) begin
         rdata_nxt = sd6_r;
      end else if (reg_req_in.addr == rvc_pkg::RVC_OFF_LDA2) begin
         rdata_nxt = lda2_r;
      end
      if (!reg_req_in.rd) rdata_nxt = rdata_r;
   end

   // ------------------------------------------------------------
   // Applied codes, taken from the next values so a write lands at once
   // ------------------------------------------------------------
   always_comb begin
      target_nxt.sd4 = sd4_nxt[rvc_pkg::RVC_SD_MSB:0];
      target_nxt.sd5 = sd5_nxt[rvc_pkg::RVC_SD_MSB:0];
      target_nxt.sd6 = sd6_nxt[rvc_pkg::RVC_SD_MSB:0];
      if (sleep_n_sync) begin
         target_nxt.lda2 = lda2_nxt[rvc_pkg::RVC_LDA2_NRM_MSB:rvc_pkg::RVC_LDA2_NRM_LSB];
      end else begin
         target_nxt.lda2 = lda2_nxt[rvc_pkg::RVC_LDA2_SLP_MSB:rvc_pkg::RVC_LDA2_SLP_LSB];
      end
      // Zero volts is legal; power-good must not drop for it
      hold_nxt[0] = (target_nxt.sd4 == 7'h00);
      hold_nxt[1] = (target_nxt.sd5 == 7'h00);
      hold_nxt[2] = (target_nxt.sd6 == 7'h00);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         sd4_r           <= rvc_pkg::RVC_RST_SD4;
         sd5_r           <= rvc_pkg::RVC_RST_SD5;
         sd6_r           <= rvc_pkg::rvc_sd6_reset(otp_variant_in);
         lda2_r          <= rvc_pkg::rvc_lda2_reset(otp_variant_in);
         rdata_r         <= 8'h00;
         rvalid_r        <= 1'b0;
         target_r.sd4    <= rvc_pkg::RVC_RST_SD4[6:0];
         target_r.sd5    <= rvc_pkg::RVC_RST_SD5[6:0];
         target_r.sd6    <= rvc_pkg::RVC_RST_SD6_A[6:0];
         target_r.lda2   <= rvc_pkg::RVC_RST_LDA2_LO[3:0];
         hold_r          <= 3'h0;
      end else begin
         sd4_r           <= sd4_nxt;
         sd5_r           <= sd5_nxt;
         sd6_r           <= sd6_nxt;
         lda2_r          <= lda2_nxt;
         rdata_r         <= rdata_nxt;
         rvalid_r        <= rvalid_nxt;
         target_r        <= target_nxt;
         hold_r          <= hold_nxt;
      end
   end

   assign reg_hit_out    = hit;
   assign reg_rdata_out  = rdata_r;
   assign reg_rvalid_out = rvalid_r;
   assign target_out     = target_r;
   assign pgood_hold_out = hold_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   sequence s_wr_sd4;
      reg_req_in.wr && (reg_req_in.addr == rvc_pkg::RVC_OFF_SD4);
   endsequence

   sequence s_rd_sd4;
      reg_req_in.rd && (reg_req_in.addr == rvc_pkg::RVC_OFF_SD4);
   endsequence

   a_sd4_reset_value: assert property (@(posedge clk_sys_in) disable iff (1'b0)
      rst_in |=> (sd4_r == rvc_pkg::RVC_RST_SD4))
      else $error("sd4 code wrong after reset");

   a_sd5_reset_value: assert property (@(posedge clk_sys_in) disable iff (1'b0)
      rst_in |=> (sd5_r == rvc_pkg::RVC_RST_SD5))
      else $error("sd5 code wrong after reset");

   a_sd6_otp_reset: assert property (@(posedge clk_sys_in) disable iff (1'b0)
      rst_in |=> (sd6_r == rvc_pkg::rvc_sd6_reset($past(otp_variant_in))))
      else $error("sd6 code does not follow variant");

   a_lda2_otp_reset: assert property (@(posedge clk_sys_in) disable iff (1'b0)
      rst_in |=> (lda2_r == rvc_pkg::rvc_lda2_reset($past(otp_variant_in))))
      else $error("a2 codes do not follow variant");

   a_sd4_write_applies: assert property (
      s_wr_sd4 |=> (target_out.sd4 == $past(wdata_lo7)) && (pgood_hold_out[0] == ($past(wdata_lo7) == 7'h00)))
      else $error("sd4 write not applied next cycle");

   a_sd4_read_back: assert property (
      s_wr_sd4 ##1 (s_rd_sd4 and (!reg_req_in.wr))
      |=> reg_rvalid_out && (reg_rdata_out == $past(reg_req_in.wdata, 2)))
      else $error("sd4 read back mismatch");

   a_lda2_sleep_code: assert property (
      !sleep_n_sync |=> (target_out.lda2 == lda2_r[7:4]))
      else $error("a2 sleep code not applied");

   a_lda2_normal_code: assert property (
      sleep_n_sync |=> (target_out.lda2 == lda2_r[3:0]))
      else $error("a2 normal code not applied");

   a_zero_code_hold: assert property (
      (target_out.sd5 == 7'h00) |-> pgood_hold_out[1])
      else $error("power-good hold missing at zero code");

   a_unmapped_read: assert property (
      (reg_req_in.rd && !hit) |=> reg_rvalid_out && (reg_rdata_out == 8'h00))
      else $error("unmapped read not zero");

endmodule
`default_nettype wire

// [testbench/rvc_regs_tb_top.sv]
// Self-checking bench for the regulator voltage code register slice
`timescale 1ns/10ps
`default_nettype none
module rvc_regs_tb_top;
   logic                  clk_sys_in;
   logic                  rst_in;
   rvc_pkg::rvc_req_t     req;
   logic                  hit;
   logic [7:0]            rdata;
   logic                  rvalid;
   rvc_pkg::rvc_variant_t variant;
   logic                  sleep_n;
   rvc_pkg::rvc_target_t  tgt;
   logic [2:0]            pgood;
   int                    bad_count;
   int                    checked;
   int                    cycles;

   rvc_regs dut (
      .clk_sys_in               (clk_sys_in),
      .rst_in                   (rst_in),
      .reg_req_in               (req),
      .reg_hit_out              (hit),
      .reg_rdata_out            (rdata),
      .reg_rvalid_out           (rvalid),
      .otp_variant_in           (variant),
      .sleep_state_request_n_in (sleep_n),
      .target_out               (tgt),
      .pgood_hold_out           (pgood)
   );

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial clk_sys_in = 1'b0;
   always #12.5 clk_sys_in = ~clk_sys_in;

   // Whole run is well under 1000 cycles
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Strobes stay up between back-to-back requests; idle drops them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tick(1);
      check("hit", {7'h00, hit}, {7'h00, a inside {8'h94, 8'h96, 8'h98, 8'h9a}});
      check("rvalid", {7'h00, rvalid}, 8'h01);
      check(name, rdata, exp);
   endtask

   task automatic idle();
      req = '0;
      tick(1);
   endtask

   task automatic do_reset(input rvc_pkg::rvc_variant_t v);
      variant = v;
      req = '0;
      rst_in = 1'b1;
      tick(10);
      rst_in = 1'b0;
      tick(1);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_variants();
      rvc_pkg::rvc_variant_t vs[4];
      logic [7:0]            sd6_e[4];
      logic [7:0]            a2_e[4];
      vs = '{rvc_pkg::RVC_VAR_A, rvc_pkg::RVC_VAR_B, rvc_pkg::RVC_VAR_C, rvc_pkg::RVC_VAR_D};
      sd6_e = '{8'h3d, 8'h47, 8'h56, 8'h3d};
      a2_e = '{8'haa, 8'haa, 8'haa, 8'h00};
      for (int i = 0; i < 4; i++) begin
         do_reset(vs[i]);
         check("sd4 target", {1'b0, tgt.sd4}, 8'h2f);
         check("sd5 target", {1'b0, tgt.sd5}, 8'h4b);
         check("sd6 target", {1'b0, tgt.sd6}, sd6_e[i]);
         check("a2 target", {4'h0, tgt.lda2}, {4'h0, a2_e[i][3:0]});
         check("pgood idle", {5'h00, pgood}, 8'h00);
         rd(8'h94, 8'h2f, "sd4 reg");
         rd(8'h96, 8'h4b, "sd5 reg");
         rd(8'h98, sd6_e[i], "sd6 reg");
         rd(8'h9a, a2_e[i], "a2 reg");
         idle();
      end
   endtask

   task automatic test_stepdown();
      logic [7:0] offs[3];
      offs = '{8'h94, 8'h96, 8'h98};
      for (int i = 0; i < 3; i++) begin
         wr(offs[i], 8'h00);
         check("pgood zero", {5'h00, pgood}, 8'h01 << i);
         wr(offs[i], 8'hd5);
         check("pgood back", {5'h00, pgood}, 8'h00);
         check("sd target", {1'b0, (i == 0) ? tgt.sd4 : (i == 1) ? tgt.sd5 : tgt.sd6}, 8'h55);
         rd(offs[i], 8'hd5, "sd reg");
      end
      // Read and write together return the old contents
      req = '{addr: 8'h94, wdata: 8'h12, wr: 1'b1, rd: 1'b1};
      tick(1);
      check("rw old", rdata, 8'hd5);
      rd(8'h94, 8'h12, "rw new");
      wr(8'h95, 8'h77);
      rd(8'h95, 8'h00, "unmapped");
      rd(8'h94, 8'h12, "neighbour");
      idle();
   endtask

   task automatic test_sleep();
      wr(8'h9a, 8'h5c);
      idle();
      check("a2 normal", {4'h0, tgt.lda2}, 8'h0c);
      sleep_n = 1'b0;
      tick(2);
      check("a2 sync", {4'h0, tgt.lda2}, 8'h0c);
      tick(1);
      check("a2 sleep", {4'h0, tgt.lda2}, 8'h05);
      wr(8'h9a, 8'h3c);
      check("a2 sleep wr", {4'h0, tgt.lda2}, 8'h03);
      idle();
      sleep_n = 1'b1;
      tick(3);
      check("a2 wake", {4'h0, tgt.lda2}, 8'h0c);
      // Equal codes give no change on entering sleep
      wr(8'h9a, 8'hcc);
      idle();
      sleep_n = 1'b0;
      tick(3);
      check("a2 equal", {4'h0, tgt.lda2}, 8'h0c);
      rd(8'h9a, 8'hcc, "a2 reg");
      idle();
   endtask

   // ------------------------------------------------------------
   // Main sequence and verdict
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      rst_in = 1'b1;
      req = '0;
      variant = rvc_pkg::RVC_VAR_A;
      sleep_n = 1'b1;
      bad_count = 0;
      checked = 0;
      cycles = 0;
      test_variants();
      test_stepdown();
      test_sleep();
      print_verdict();
   end
endmodule
`default_nettype wire
